// file: shared/fbg_pkg.sv
// Constants and types shared by the fractional baud generator
package fbg_pkg;

    // Byte offsets of the word registers on the bus
    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] FRAC_OFFSET     = 8'h04;
    localparam logic [7:0] SRC_OFFSET      = 8'h08;
    localparam logic [7:0] STATUS_OFFSET   = 8'h0c;

    // Control register fields
    localparam int         CTRL_EN_POS     = 7;
    localparam int         CTRL_DIV_LSB    = 0;
    localparam int         CTRL_DIV_W      = 3;

    // Source select register fields
    localparam int         SRC_DOUBLE_POS  = 0;
    localparam int         SRC_T2TX_POS    = 1;
    localparam int         SRC_T2RX_POS    = 2;
    localparam int         SRC_MODE_LSB    = 3;

    // Status register fields
    localparam int         STAT_GEN_POS    = 0;
    localparam int         STAT_T2TX_POS   = 1;
    localparam int         STAT_T2RX_POS   = 2;
    localparam int         STAT_TXCNT_LSB  = 8;
    localparam int         STAT_RXCNT_LSB  = 16;

    // Reset values
    localparam logic       CTRL_EN_RST     = 1'b0;
    localparam logic [2:0] CTRL_DIV_RST    = 3'h0;
    localparam logic [7:0] FRAC_RST        = 8'h00;
    localparam logic [2:0] SRC_SEL_RST     = 3'h0;

    // Divider figures
    localparam int         ACC_W           = 9;
    localparam int         PRESC_W         = 7;
    localparam logic [8:0] FRAC_BIAS       = 9'h040;
    localparam logic [1:0] GEN_STEP        = 2'h2;
    localparam logic [1:0] UNIT_STEP       = 2'h1;
    localparam logic [8:0] T1_DIV_SLOW     = 9'h020;
    localparam logic [8:0] T1_DIV_FAST     = 9'h010;
    localparam logic [8:0] T2_DIV          = 9'h010;
    localparam logic [8:0] SHIFT_DIV       = 9'h00c;
    localparam logic [8:0] FIX9_DIV_SLOW   = 9'h040;
    localparam logic [8:0] FIX9_DIV_FAST   = 9'h020;

    // Serial port modes
    typedef enum logic [1:0] {
        FBG_SHIFT,
        FBG_VAR8,
        FBG_FIX9,
        FBG_VAR9
    } fbg_mode_t;

endpackage

// file: shared/fbg_div_if.sv
// Link between the top and one fractional pulse divider
interface fbg_div_if;
    import fbg_pkg::*;
    logic             pulse_in;
    logic             clr;
    logic [1:0]       step;
    logic [ACC_W-1:0] modulus;
    logic             tick;
    modport ctrl (output pulse_in, output clr, output step, output modulus, input tick);
    modport div  (input pulse_in, input clr, input step, input modulus, output tick);
endinterface

// file: core/fbg_frac_div.sv
// Fractional pulse divider: adds step per input pulse, ticks on wrap
module fbg_frac_div
    import fbg_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    fbg_div_if.div    dv
);
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic             tick_q;
    logic             tick_d;
    logic [ACC_W:0]   sum;

    // Accumulate and wrap against the modulus
    always_comb begin
        sum    = {1'b0, acc_q} + {{(ACC_W - 1){1'b0}}, dv.step};
        acc_d  = acc_q;
        tick_d = 1'b0;
        if (dv.clr) begin
            acc_d = '0;
        end else if (dv.pulse_in) begin
            if (sum >= {1'b0, dv.modulus}) begin
                // Restart at zero if a modulus drop left the count out of range
                acc_d  = (acc_q >= dv.modulus) ? '0 : ACC_W'(sum - {1'b0, dv.modulus});
                tick_d = 1'b1;
            end else begin
                acc_d = sum[ACC_W-1:0];
            end
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick = tick_q;
endmodule

// file: core/fbg_top.sv
// Fractional baud generator with classic timer sources and AHB-Lite registers
module fbg_top
    import fbg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        timer1_overflow,
    input  wire logic        timer2_overflow,
    output logic             tx_baud_tick,
    output logic             rx_baud_tick
);
    // Bus phase state
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [7:0]  wr_addr_q;
    logic [7:0]  wr_addr_d;
    logic        addr_phase;

    // Software registers
    logic        generator_enable_q;
    logic        generator_enable_d;
    logic [2:0]  prescale_q;
    logic [2:0]  prescale_d;
    logic [7:0]  fractional_divide_value_q;
    logic [7:0]  fractional_divide_value_d;
    logic        rate_double_bit_q;
    logic        rate_double_bit_d;
    logic        timer2_transmit_baud_select_q;
    logic        timer2_transmit_baud_select_d;
    logic        timer2_receive_baud_select_q;
    logic        timer2_receive_baud_select_d;
    fbg_mode_t   mode_q;
    fbg_mode_t   mode_d;

    // Read data and fixed answers
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic        hreadyout_q;
    logic        hresp_q;

    // Tick path state
    logic [PRESC_W-1:0] presc_cnt_q;
    logic [PRESC_W-1:0] presc_cnt_d;
    logic [PRESC_W-1:0] presc_mask;
    logic               presc_pulse;
    logic               var_mode;
    logic               tx_t2;
    logic               rx_t2;
    logic               tx_tick_q;
    logic               tx_tick_d;
    logic               rx_tick_q;
    logic               rx_tick_d;
    logic [7:0]         tx_count_q;
    logic [7:0]         tx_count_d;
    logic [7:0]         rx_count_q;
    logic [7:0]         rx_count_d;

    // Dividers: 0 generator, 1 classic transmit, 2 classic receive, 3 fixed
    localparam int NDIV = 4;
    fbg_div_if dv [NDIV] ();
    logic             div_pulse [NDIV];
    logic             div_clr   [NDIV];
    logic [1:0]       div_step  [NDIV];
    logic [ACC_W-1:0] div_mod   [NDIV];
    logic             div_tick  [NDIV];

    for (genvar i = 0; i < NDIV; i++) begin : g_div
        assign dv[i].pulse_in = div_pulse[i];
        assign dv[i].clr      = div_clr[i];
        assign dv[i].step     = div_step[i];
        assign dv[i].modulus  = div_mod[i];
        assign div_tick[i]    = dv[i].tick;
        fbg_frac_div u_div (
            .clock (clock),
            .rst   (rst),
            .dv    (dv[i])
        );
    end

    // Address phase accepted when selected, active and bus ready
    assign addr_phase = hsel & htrans[1] & hready;

    // Bus phase tracking
    always_comb begin
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        if (addr_phase) begin
            wr_pend_d = hwrite;
            wr_addr_d = haddr[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // Register writes in the data phase
    always_comb begin
        generator_enable_d            = generator_enable_q;
        prescale_d                    = prescale_q;
        fractional_divide_value_d     = fractional_divide_value_q;
        rate_double_bit_d             = rate_double_bit_q;
        timer2_transmit_baud_select_d = timer2_transmit_baud_select_q;
        timer2_receive_baud_select_d  = timer2_receive_baud_select_q;
        mode_d                        = mode_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                CTRL_OFFSET: begin
                    generator_enable_d = hwdata[CTRL_EN_POS];
                    prescale_d = hwdata[CTRL_DIV_LSB +: CTRL_DIV_W];
                end
                FRAC_OFFSET: begin
                    fractional_divide_value_d = hwdata[7:0];
                end
                SRC_OFFSET: begin
                    rate_double_bit_d             = hwdata[SRC_DOUBLE_POS];
                    timer2_transmit_baud_select_d = hwdata[SRC_T2TX_POS];
                    timer2_receive_baud_select_d  = hwdata[SRC_T2RX_POS];
                    mode_d = fbg_mode_t'(hwdata[SRC_MODE_LSB +: 2]);
                end
                default: begin
                    mode_d = mode_q;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            generator_enable_q            <= CTRL_EN_RST;
            prescale_q                    <= CTRL_DIV_RST;
            fractional_divide_value_q     <= FRAC_RST;
            rate_double_bit_q             <= SRC_SEL_RST[SRC_DOUBLE_POS];
            timer2_transmit_baud_select_q <= SRC_SEL_RST[SRC_T2TX_POS];
            timer2_receive_baud_select_q  <= SRC_SEL_RST[SRC_T2RX_POS];
            mode_q                        <= FBG_SHIFT;
        end else begin
            generator_enable_q            <= generator_enable_d;
            prescale_q                    <= prescale_d;
            fractional_divide_value_q     <= fractional_divide_value_d;
            rate_double_bit_q             <= rate_double_bit_d;
            timer2_transmit_baud_select_q <= timer2_transmit_baud_select_d;
            timer2_receive_baud_select_q  <= timer2_receive_baud_select_d;
            mode_q                        <= mode_d;
        end
    end

    // Control, fraction and source read from next values, so a write just before is seen; status reads registered values
    always_comb begin
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite) begin
            hrdata_d = 32'h0000_0000;
            case (haddr[7:0])
                CTRL_OFFSET: begin
                    hrdata_d[CTRL_EN_POS] = generator_enable_d;
                    hrdata_d[CTRL_DIV_LSB +: CTRL_DIV_W] = prescale_d;
                end
                FRAC_OFFSET: begin
                    hrdata_d[7:0] = fractional_divide_value_d;
                end
                SRC_OFFSET: begin
                    hrdata_d[SRC_DOUBLE_POS]     = rate_double_bit_d;
                    hrdata_d[SRC_T2TX_POS]       = timer2_transmit_baud_select_d;
                    hrdata_d[SRC_T2RX_POS]       = timer2_receive_baud_select_d;
                    hrdata_d[SRC_MODE_LSB +: 2]  = mode_d;
                end
                STATUS_OFFSET: begin
                    hrdata_d[STAT_GEN_POS]            = generator_enable_q & var_mode;
                    hrdata_d[STAT_T2TX_POS]           = tx_t2;
                    hrdata_d[STAT_T2RX_POS]           = rx_t2;
                    hrdata_d[STAT_TXCNT_LSB +: 8]     = tx_count_q;
                    hrdata_d[STAT_RXCNT_LSB +: 8]     = rx_count_q;
                end
                default: begin
                    hrdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge clock) begin
        if (rst) begin
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            hrdata_q    <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // Source decode
    always_comb begin
        var_mode = (mode_q == FBG_VAR8) || (mode_q == FBG_VAR9);
        // Timer 2 per direction when generator off
        tx_t2 = !generator_enable_q && timer2_transmit_baud_select_q;
        rx_t2 = !generator_enable_q && timer2_receive_baud_select_q;
    end

    // power-of-two prescaler on the core clock
    always_comb begin
        presc_mask  = PRESC_W'((8'h01 << prescale_q) - 8'h01);
        presc_pulse = (presc_cnt_q & presc_mask) == presc_mask;
        presc_cnt_d = generator_enable_q ? presc_cnt_q + 7'h01 : 7'h00;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            presc_cnt_q <= 7'h00;
        end else begin
            presc_cnt_q <= presc_cnt_d;
        end
    end

    // Divider steering
    always_comb begin
        // generator paced by the prescaled core clock
        // two per prescaled pulse against value plus 64
        div_pulse[0] = presc_pulse;
        div_clr[0]   = !generator_enable_q;
        div_step[0]  = GEN_STEP;
        div_mod[0]   = {1'b0, fractional_divide_value_q} + FRAC_BIAS;
        div_pulse[1] = tx_t2 ? timer2_overflow : timer1_overflow;
        div_clr[1]   = generator_enable_q;
        div_step[1]  = UNIT_STEP;
        div_mod[1]   = tx_t2 ? T2_DIV : (rate_double_bit_q ? T1_DIV_FAST : T1_DIV_SLOW);
        div_pulse[2] = rx_t2 ? timer2_overflow : timer1_overflow;
        div_clr[2]   = generator_enable_q;
        div_step[2]  = UNIT_STEP;
        div_mod[2]   = rx_t2 ? T2_DIV : (rate_double_bit_q ? T1_DIV_FAST : T1_DIV_SLOW);
        div_pulse[3] = 1'b1;
        div_clr[3]   = var_mode;
        div_step[3]  = UNIT_STEP;
        case (mode_q)
            FBG_SHIFT: div_mod[3] = SHIFT_DIV;
            FBG_FIX9:  div_mod[3] = rate_double_bit_q ? FIX9_DIV_FAST : FIX9_DIV_SLOW;
            default:   div_mod[3] = SHIFT_DIV;
        endcase
    end

    // Output tick selection and tick counts
    always_comb begin
        if (!var_mode) begin
            tx_tick_d = div_tick[3];
            rx_tick_d = div_tick[3];
        end else if (generator_enable_q) begin
            tx_tick_d = div_tick[0];
            rx_tick_d = div_tick[0];
        end else begin
            tx_tick_d = div_tick[1];
            rx_tick_d = div_tick[2];
        end
        tx_count_d = tx_count_q + {7'h00, tx_tick_d};
        rx_count_d = rx_count_q + {7'h00, rx_tick_d};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_tick_q  <= 1'b0;
            rx_tick_q  <= 1'b0;
            tx_count_q <= 8'h00;
            rx_count_q <= 8'h00;
        end else begin
            tx_tick_q  <= tx_tick_d;
            rx_tick_q  <= rx_tick_d;
            tx_count_q <= tx_count_d;
            rx_count_q <= rx_count_d;
        end
    end

    // Outputs straight from flip-flops
    assign hreadyout    = hreadyout_q;
    assign hresp        = hresp_q;
    assign hrdata       = hrdata_q;
    assign tx_baud_tick = tx_tick_q;
    assign rx_baud_tick = rx_tick_q;
endmodule

// file: sim/fbg_chk.sv
// Port checker for the fractional baud generator
module fbg_chk
    import fbg_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        tx_baud_tick,
    input wire logic        rx_baud_tick
);
    logic rd_q, rd_d, ctl_q, ctl_d, unm_q, unm_d;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Read address phases taken by the slave
    always_comb begin
        rd_d  = hsel && htrans[1] && hready && !hwrite;
        ctl_d = rd_d && (haddr[7:0] == CTRL_OFFSET);
        unm_d = rd_d && (haddr[7:0] > STATUS_OFFSET);
    end
    // Data phase flags
    always_ff @(posedge clock) begin
        rd_q  <= rst ? 1'b0 : rd_d;
        ctl_q <= rst ? 1'b0 : ctl_d;
        unm_q <= rst ? 1'b0 : unm_d;
    end
    property p_ready; hreadyout == 1'b1; endproperty
    property p_okay; hresp == 1'b0; endproperty
    property p_tx_one; tx_baud_tick |=> !tx_baud_tick; endproperty
    property p_rx_one; rx_baud_tick |=> !rx_baud_tick; endproperty
    property p_resv; ctl_q |-> hrdata[6:3] == 4'h0 && hrdata[31:8] == 24'h0; endproperty
    property p_unmapped; unm_q |-> hrdata == 32'h0; endproperty
    property p_hold; !rd_q && !$past(rst) |-> $stable(hrdata); endproperty
    property p_mode0; $fell(rst) |-> ##[1:14] tx_baud_tick; endproperty
    a_ready: assert property (p_ready) else $error("ready dropped");
    a_okay: assert property (p_okay) else $error("error response");
    a_tx_one: assert property (p_tx_one) else $error("tx tick too long");
    a_rx_one: assert property (p_rx_one) else $error("rx tick too long");
    a_resv: assert property (p_resv) else $error("reserved control bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data changed");
    a_mode0: assert property (p_mode0) else $error("no tick after reset");
    c_both: cover property (tx_baud_tick && rx_baud_tick);
    c_ctl: cover property (ctl_q);
    c_unm: cover property (unm_q);
endmodule

bind fbg_top fbg_chk chk_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick));

// file: sim/fbg_uart_sink.sv
// Tick counter model that consumes the baud ticks
module fbg_uart_sink (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic tx_baud_tick,
    input  wire logic rx_baud_tick,
    output int        tx_n,
    output int        rx_n,
    output int        tx_t,
    output int        rx_t
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    // One bit time per tick, stamped in core clocks
    // tick per bit
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rst) begin
            tx_n <= 0;
            rx_n <= 0;
        end else begin
            if (tx_baud_tick === 1'b1) begin
                tx_n <= tx_n + 1;
                tx_t <= cyc;
            end
            if (rx_baud_tick === 1'b1) begin
                rx_n <= rx_n + 1;
                rx_t <= cyc;
            end
        end
    end
endmodule

// file: sim/test_fractional_uart_baud_generator.sv
// Self-checking bench for the fractional baud generator
module test_fractional_uart_baud_generator
    import fbg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T1P = 3;
    localparam int T2P = 5;
    logic        clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hready, hreadyout, hresp, tx_baud_tick, rx_baud_tick;
    logic        timer1_overflow = 1'b0, timer2_overflow = 1'b0;
    int          errors = 0, total_checks = 0, ovf_c = 0, tx_n, rx_n, tx_t, rx_t, s, e;
    logic [7:0]  cw [5] = '{8'h80, 8'h81, 8'h83, 8'h87, 8'h82};
    logic [7:0]  fd [5] = '{8'h2d, 8'h2d, 8'h12, 8'h00, 8'hff};
    assign hready = hreadyout;
    always #5 clock = ~clock;
    // Timer overflow pulses at fixed spacing
    always @(posedge clock) begin
        ovf_c <= ovf_c + 1;
        timer1_overflow <= (ovf_c % T1P) == 0;
        timer2_overflow <= (ovf_c % T2P) == 0;
    end
    fbg_top dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
        .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick));
    fbg_uart_sink sink_u (.clock(clock), .rst(rst), .tx_baud_tick(tx_baud_tick),
        .rx_baud_tick(rx_baud_tick), .tx_n(tx_n), .rx_n(rx_n), .tx_t(tx_t), .rx_t(rx_t));
    // Single whole-word transfer on the register bus
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge clock); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_span(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            errors++;
            $display("ERROR at %0t: two-tick span %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        cmp_reg(rd & m, exp);
    endtask
    // Clocks spanned by two ticks, after the settling ones are skipped
    task automatic two(input bit rx, output int sp);
        int n, t;
        n = rx ? rx_n : tx_n;
        wait ((rx ? rx_n : tx_n) == n + 3);
        #1 t = rx ? rx_t : tx_t;
        wait ((rx ? rx_n : tx_n) == n + 5);
        #1 sp = (rx ? rx_t : tx_t) - t;
    endtask
    task automatic rate(input logic [7:0] src, input int etx, input int erx);
        bus(1'b1, SRC_OFFSET, {24'h0, src});
        two(1'b0, s);
        cmp_span(s, etx);
        two(1'b1, s);
        cmp_span(s, erx);
    endtask
    task automatic close_out();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (80000) @(posedge clock);
        errors++;
        $display("ERROR at %0t: run timed out", $time);
        close_out();
    end
    // Test sequence
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (20) @(posedge clock);
        rdc(CTRL_OFFSET, 32'h0, 32'hffffffff);
        rdc(FRAC_OFFSET, 32'h0, 32'hffffffff);
        rdc(SRC_OFFSET, 32'h0, 32'hffffffff);
        rdc(STATUS_OFFSET, 32'h0, 32'h7);
        bus(1'b1, CTRL_OFFSET, 32'hffffff7f);
        rdc(CTRL_OFFSET, 32'h7, 32'hffffffff);
        bus(1'b1, 8'h10, 32'hffffffff);
        rdc(8'h10, 32'h0, 32'hffffffff);
        $display("test registers done");
        rate(8'h00, 24, 24);
        rate(8'h10, 128, 128);
        rate(8'h11, 64, 64);
        bus(1'b1, CTRL_OFFSET, 32'h80);
        rate(8'h10, 128, 128);
        $display("test fixed modes done");
        bus(1'b1, CTRL_OFFSET, 32'h0);
        rate(8'h08, 64 * T1P, 64 * T1P);
        rate(8'h09, 32 * T1P, 32 * T1P);
        rate(8'h0a, 32 * T2P, 64 * T1P);
        rdc(STATUS_OFFSET, 32'h2, 32'h7);
        rate(8'h1c, 64 * T1P, 32 * T2P);
        $display("test timer sources done");
        // Settings picked as software would for each wanted rate
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, FRAC_OFFSET, {24'h0, fd[i]});
            bus(1'b1, CTRL_OFFSET, {24'h0, cw[i]});
            e = (1 << cw[i][2:0]) * (fd[i] + 64);
            rate(i[0] ? 8'h1f : 8'h0f, e, e);
            rdc(STATUS_OFFSET, 32'h1, 32'h7);
        end
        $display("test generator done");
        close_out();
    end
endmodule
